//--- verification/tkca_core_tb.sv
`timescale 1ns/1ns
module tkca_core_tb;
  typedef struct packed {logic rd; logic err; logic [31:0] d;} tkca_note_t;
  logic core_clk, rstn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic pready, pslverr, irq_oen, sec_oen, io_line, irq_pin;
  tkca_note_t notes[$];
  tkca_note_t nt;
  int fail_count, num_checks;

  ////////////////////////////////////////////////////////////////////////////////
  // Short qualifier limits keep the run brief
  tkca_core #(.LONG_CYC(21'h00_0028), .SHORT_CYC(21'h00_000A)) dut_u (
    .CORE_CLK(core_clk),
    .RSTN(rstn),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .IO_LINE(io_line),
    .IRQ_OEN(irq_oen),
    .SECOND_PULSE_OUT_OEN(sec_oen)
  );

  tkca_line_model line_u (.clk(core_clk), .irq_oen(irq_oen), .io_line(io_line), .irq_pin(irq_pin));

  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One APB transfer; the expected answer goes on the note queue
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ed,
                     input logic ee);
    int n;
    notes.push_back('{rd: !wr, err: ee, d: ed});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0000_0000, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, e, 1'b0);
  endtask

  // Bounded wait for the interrupt pin to go low
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_pin !== 1'b0 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      close_out();
    end
  endtask

  task automatic done(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Response watcher: oldest note against each answer
  always @(posedge core_clk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h0000_0001, 32'h0000_0000);
      end else begin
        nt = notes.pop_front();
        check({31'h0000_0000, pslverr}, {31'h0000_0000, nt.err});
        if (nt.rd) begin
          check(prdata, nt.d);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fail_count = 0;
    num_checks = 0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rnd = $urandom(99085);
    rd(tkca_pkg::A_CTRL, 32'h0000_0000);
    rd(tkca_pkg::A_STAT, 32'h0000_0038);
    apb(1'b0, 8'h3C, 32'h0000_0000, 32'h0000_0000, 1'b1);
    check({31'h0000_0000, irq_pin}, 32'h0000_0001);
    check({31'h0000_0000, sec_oen}, 32'h0000_0000);
    done("reset");
    // Snapshot returns the value written to the live counter
    rnd = $urandom;
    wr(tkca_pkg::A_RTC_LO, rnd);
    wr(tkca_pkg::A_SNAP, 32'h0000_0000);
    rd(tkca_pkg::A_RTC_LO, rnd);
    done("snapshot");
    // Line cycles with the oscillator off are not counted
    line_u.pulse(30, 30);
    line_u.pulse(30, 30);
    wr(tkca_pkg::A_SNAP, 32'h0000_0000);
    rd(tkca_pkg::A_CYC, 32'h0000_0000);
    done("osc_off");
    // Qualified cycles counted, short highs ignored, both delay settings
    wr(tkca_pkg::A_CAL, 32'h0000_0004);
    wr(tkca_pkg::A_STAT, 32'h0000_0000);
    wr(tkca_pkg::A_CTRL, 32'h0000_0010);
    repeat (3) line_u.pulse(30, 30);
    repeat (2) line_u.pulse(5, 30);
    wr(tkca_pkg::A_CTRL, 32'h0000_0090);
    line_u.pulse(20, 60);
    line_u.pulse(60, 60);
    wait_irq(200);
    wr(tkca_pkg::A_SNAP, 32'h0000_0000);
    rd(tkca_pkg::A_CYC, 32'h0000_0004);
    rd(tkca_pkg::A_STAT, 32'h0000_0004);
    rd(tkca_pkg::A_STAT, 32'h0000_0000);
    repeat (3) @(posedge core_clk);
    check({31'h0000_0000, irq_pin}, 32'h0000_0001);
    done("cycles");
    // Auto mode with line high: timer runs, run/stop ignored, clock wraps
    wr(tkca_pkg::A_RTC_LO, 32'hFFFF_FFFF);
    wr(tkca_pkg::A_RTC_HI, 32'h0000_00FF);
    wr(tkca_pkg::A_ITM_LO, 32'h0000_0000);
    wr(tkca_pkg::A_ITM_HI, 32'h0000_0000);
    wr(tkca_pkg::A_IAL_LO, 32'h0000_0001);
    line_u.hold(1'b1, 20);
    wr(tkca_pkg::A_CTRL, 32'h0000_0070);
    wait_irq(40000);
    repeat (3) @(posedge core_clk);
    rd(tkca_pkg::A_STAT, 32'h0000_0003);
    wr(tkca_pkg::A_SNAP, 32'h0000_0000);
    rd(tkca_pkg::A_RTC_LO, 32'h0000_0000);
    rd(tkca_pkg::A_RTC_HI, 32'h0000_0000);
    rd(tkca_pkg::A_ITM_LO, 32'h0000_0001);
    done("auto_tick");
    // Manual mode halted: only the clock advances
    wr(tkca_pkg::A_CTRL, 32'h0000_0050);
    wr(tkca_pkg::A_RAL_LO, 32'h0000_0001);
    wait_irq(40000);
    repeat (3) @(posedge core_clk);
    rd(tkca_pkg::A_STAT, 32'h0000_0001);
    wr(tkca_pkg::A_SNAP, 32'h0000_0000);
    rd(tkca_pkg::A_RTC_LO, 32'h0000_0001);
    rd(tkca_pkg::A_ITM_LO, 32'h0000_0001);
    done("manual_halt");
    // Alarm on a protected counter expires the device; read-only keeps reads open
    wr(tkca_pkg::A_CAL, 32'h0000_0005);
    wr(tkca_pkg::A_CTRL, 32'h0000_001C);
    line_u.pulse(30, 30);
    apb(1'b1, tkca_pkg::A_CTRL, 32'h0000_0010, 32'h0000_0000, 1'b1);
    rd(tkca_pkg::A_EXP, 32'h0000_0001);
    done("expire");
    repeat (4) @(posedge core_clk);
    close_out();
  end
endmodule

//--- verification/tkca_line_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Far-side model: drives the single-wire line and pulls up the interrupt pin
module tkca_line_model (
  input wire logic clk,
  input wire logic irq_oen,
  output logic io_line,
  output logic irq_pin
);
  // Open-drain pin with pull-up, low only while the device pulls it
  assign irq_pin = irq_oen ? 1'b1 : 1'b0;

  // Line starts low so that nothing qualifies before the bench asks
  initial begin
    io_line = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Hold the line at one level for a number of clock cycles
  task automatic hold(input logic lvl, input int cyc);
    io_line <= lvl;
    repeat (cyc) @(posedge clk);
  endtask

  // One line cycle: high time, then low time
  task automatic pulse(input int hi, input int lo);
    hold(1'b1, hi);
    hold(1'b0, lo);
  endtask
endmodule

//--- verilog/tkca_core.sv
// Contract
// - All timekeeping runs from the 32.768kHz oscillator, only while it runs.
// - The oscillator enable bit in the control register starts and stops it.
// - A snapshot copies all counters to holding registers; reads return those.
// - Real-time clock is a 40-bit counter advancing 256 times per second.
// - Low byte is 1/256 seconds, upper four bytes whole seconds.
// - Interval timer is 40 bits, advancing 256 times per second when enabled.
// - Mode select bit picks automatic or manual interval timer operation.
// - Auto mode: timer starts once the line stays high for the delay.
// - Auto mode: timer stops once the line stays low for the delay.
// - Manual mode: only the run/stop bit enables or halts the timer.
// - Cycle counter is a 32-bit count of line cycles.
// - Cycle counter advances on a falling edge after a qualified high time.
// - Each counter sets its alarm flag when it equals its alarm register.
// - A set flag with its enable active drives the interrupt output.
// - Alarm on a protected counter and alarm restricts device access.
// - Delay select one needs about 123 ms, zero about 3.5 ms.
// - Mode select one means automatic, zero means manual.
// - Manual mode counts while run/stop is zero, halts at one.
// - Oscillator enable one starts the oscillator, zero stops it.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
module tkca_core #(
  parameter logic [20:0] LONG_CYC = tkca_pkg::LONG_CYC,
  parameter logic [20:0] SHORT_CYC = tkca_pkg::SHORT_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic IO_LINE,
  output logic IRQ_OEN,
  output logic SECOND_PULSE_OUT_OEN
);
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic acc;
  logic [7:0] ctrl_q;
  logic [2:0] flag_q;
  logic [2:0] ie_n_q;
  logic expired_q;
  logic irq_n_q;
  logic [39:0] rtc_q;
  logic [39:0] itm_q;
  logic [31:0] cyc_q;
  logic [39:0] rtc_al_q;
  logic [39:0] itm_al_q;
  logic [31:0] cyc_al_q;
  logic [39:0] rtc_h_q;
  logic [39:0] itm_h_q;
  logic [31:0] cyc_h_q;
  logic [23:0] ph_q;
  logic [24:0] ph_sum;
  logic osc_pulse;
  logic [6:0] div_q;
  logic tick;
  logic [7:0] sec_q;
  logic itm_run;
  logic [2:0] eq;
  logic [2:0] eq_prev_q;
  logic [2:0] alarm_ev;
  logic [39:0] cnt_v [3];
  logic [39:0] al_v [3];
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_d;
  logic rd_map;
  tkca_qual_if qif ();

  // True when this edge completes a write to the given register
  function automatic logic wr_hit(input logic a, input logic w, input logic [7:0] p, input logic [7:0] off);
    return a && w && (p == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered
  assign acc = PSEL && PENABLE && pready_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;
  // Expired with read-only set blocks writes; expired otherwise blocks all
  assign wr_ok = !expired_q;
  assign rd_ok = !expired_q || ctrl_q[tkca_pkg::C_RO];

  // Read mux over holding registers and live control state
  always_comb begin
    rd_d = 32'h0000_0000;
    rd_map = 1'b1;
    case (PADDR)
      tkca_pkg::A_CTRL: rd_d = {24'h00_0000, ctrl_q};
      tkca_pkg::A_STAT: rd_d = {26'h000_0000, ie_n_q, flag_q};
      tkca_pkg::A_RTC_LO: rd_d = rtc_h_q[31:0];
      tkca_pkg::A_RTC_HI: rd_d = {24'h00_0000, rtc_h_q[39:32]};
      tkca_pkg::A_ITM_LO: rd_d = itm_h_q[31:0];
      tkca_pkg::A_ITM_HI: rd_d = {24'h00_0000, itm_h_q[39:32]};
      tkca_pkg::A_CYC: rd_d = cyc_h_q;
      tkca_pkg::A_RAL_LO: rd_d = rtc_al_q[31:0];
      tkca_pkg::A_RAL_HI: rd_d = {24'h00_0000, rtc_al_q[39:32]};
      tkca_pkg::A_IAL_LO: rd_d = itm_al_q[31:0];
      tkca_pkg::A_IAL_HI: rd_d = {24'h00_0000, itm_al_q[39:32]};
      tkca_pkg::A_CAL: rd_d = cyc_al_q;
      tkca_pkg::A_SNAP: rd_d = 32'h0000_0000;
      tkca_pkg::A_EXP: rd_d = {31'h0000_0000, expired_q};
      default: rd_map = 1'b0;
    endcase
  end

  // Answer one cycle into the access phase
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= PSEL && PENABLE && !pready_q;
      pslverr_q <= PSEL && PENABLE && !pready_q && (!rd_map || (PWRITE ? !wr_ok : !rd_ok));
      prdata_q <= (PSEL && PENABLE && !pready_q && !PWRITE && rd_ok) ? rd_d : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register; protect bits can only be set, read-only bit locks with them
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ctrl_q <= tkca_pkg::CTRL_RST;
    end else if (wr_ok && wr_hit(acc, PWRITE, PADDR, tkca_pkg::A_CTRL)) begin
      ctrl_q[2:0] <= ctrl_q[2:0] | PWDATA[2:0];
      ctrl_q[tkca_pkg::C_RO] <= (|ctrl_q[2:0]) ? ctrl_q[tkca_pkg::C_RO] : PWDATA[tkca_pkg::C_RO];
      ctrl_q[7:4] <= PWDATA[7:4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Crystal model: exact 32.768kHz enable by phase accumulation
  assign ph_sum = {1'b0, ph_q} + {1'b0, tkca_pkg::OSC_HZ};
  assign osc_pulse = ctrl_q[tkca_pkg::C_OSC] && (ph_sum >= {1'b0, tkca_pkg::CLK_HZ});
  assign tick = osc_pulse && (div_q == 7'h7F);
  assign SECOND_PULSE_OUT_OEN = sec_q[7];

  // Oscillator phase, stopped while disabled
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ph_q <= 24'h00_0000;
    end else if (ctrl_q[tkca_pkg::C_OSC]) begin
      ph_q <= osc_pulse ? 24'(ph_sum - {1'b0, tkca_pkg::CLK_HZ}) : ph_sum[23:0];
    end
  end

  // Divide by 128 for the tick, by 256 more for the 1 Hz square wave
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      div_q <= 7'h00;
      sec_q <= 8'h00;
    end else if (osc_pulse) begin
      div_q <= div_q + 7'h01;
      if (tick) begin
        sec_q <= sec_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line qualifier
  assign qif.io_level = IO_LINE;
  assign qif.edge_delay_select = ctrl_q[tkca_pkg::C_EDGE_DELAY_SELECT];
  assign qif.run_en = ctrl_q[tkca_pkg::C_OSC];

  tkca_qual #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_qual (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .q(qif)
  );

  // Timer enable: line gate in auto mode, active-low run/stop in manual
  assign itm_run = ctrl_q[tkca_pkg::C_MODE] ? qif.auto_gate : !ctrl_q[tkca_pkg::C_STOP];

  ////////////////////////////////////////////////////////////////////////
  // Real-time clock: free running, wraps silently
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      rtc_q <= 40'h00_0000_0000;
    end else if (!ctrl_q[tkca_pkg::C_WPR] && wr_ok && wr_hit(acc, PWRITE, PADDR, tkca_pkg::A_RTC_LO)) begin
      rtc_q[31:0] <= PWDATA;
    end else if (!ctrl_q[tkca_pkg::C_WPR] && wr_ok && wr_hit(acc, PWRITE, PADDR, tkca_pkg::A_RTC_HI)) begin
      rtc_q[39:32] <= PWDATA[7:0];
    end else if (tick) begin
      rtc_q <= rtc_q + 40'h00_0000_0001;
    end
  end

  // Interval timer: advances on the tick only while enabled
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      itm_q <= 40'h00_0000_0000;
    end else if (!ctrl_q[tkca_pkg::C_WPI] && wr_ok && wr_hit(acc, PWRITE, PADDR, tkca_pkg::A_ITM_LO)) begin
      itm_q[31:0] <= PWDATA;
    end else if (!ctrl_q[tkca_pkg::C_WPI] && wr_ok && wr_hit(acc, PWRITE, PADDR, tkca_pkg::A_ITM_HI)) begin
      itm_q[39:32] <= PWDATA[7:0];
    end else if (tick && itm_run) begin
      itm_q <= itm_q + 40'h00_0000_0001;
    end
  end

  // Cycle counter: one per qualified line cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      cyc_q <= 32'h0000_0000;
    end else if (!ctrl_q[tkca_pkg::C_WPC] && wr_ok && wr_hit(acc, PWRITE, PADDR, tkca_pkg::A_CYC)) begin
      cyc_q <= PWDATA;
    end else if (qif.cycle_step) begin
      cyc_q <= cyc_q + 32'h0000_0001;
    end
  end

  // Alarm registers, locked with their counter
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      rtc_al_q <= 40'h00_0000_0000;
      itm_al_q <= 40'h00_0000_0000;
      cyc_al_q <= 32'h0000_0000;
    end else if (wr_ok && acc && PWRITE) begin
      if (!ctrl_q[tkca_pkg::C_WPR] && PADDR == tkca_pkg::A_RAL_LO) rtc_al_q[31:0] <= PWDATA;
      if (!ctrl_q[tkca_pkg::C_WPR] && PADDR == tkca_pkg::A_RAL_HI) rtc_al_q[39:32] <= PWDATA[7:0];
      if (!ctrl_q[tkca_pkg::C_WPI] && PADDR == tkca_pkg::A_IAL_LO) itm_al_q[31:0] <= PWDATA;
      if (!ctrl_q[tkca_pkg::C_WPI] && PADDR == tkca_pkg::A_IAL_HI) itm_al_q[39:32] <= PWDATA[7:0];
      if (!ctrl_q[tkca_pkg::C_WPC] && PADDR == tkca_pkg::A_CAL) cyc_al_q <= PWDATA;
    end
  end

  // Snapshot into holding registers on a snapshot write
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      rtc_h_q <= 40'h00_0000_0000;
      itm_h_q <= 40'h00_0000_0000;
      cyc_h_q <= 32'h0000_0000;
    end else if (rd_ok && wr_hit(acc, PWRITE, PADDR, tkca_pkg::A_SNAP)) begin
      rtc_h_q <= rtc_q;
      itm_h_q <= itm_q;
      cyc_h_q <= cyc_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm compare, one lane per counter
  assign cnt_v[0] = rtc_q;
  assign cnt_v[1] = itm_q;
  assign cnt_v[2] = {8'h00, cyc_q};
  assign al_v[0] = rtc_al_q;
  assign al_v[1] = itm_al_q;
  assign al_v[2] = {8'h00, cyc_al_q};

  for (genvar k = 0; k < 3; k++) begin : g_alarm
    assign eq[k] = (cnt_v[k] == al_v[k]);
    assign alarm_ev[k] = eq[k] && !eq_prev_q[k];
  end

  // Equality history so a match fires once
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      eq_prev_q <= 3'h7;
    end else begin
      eq_prev_q <= eq;
    end
  end

  // Sticky flags, cleared by reading status; a new alarm wins over the clear
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      flag_q <= 3'h0;
    end else if (rd_ok && acc && !PWRITE && PADDR == tkca_pkg::A_STAT) begin
      flag_q <= alarm_ev;
    end else begin
      flag_q <= flag_q | alarm_ev;
    end
  end

  // Active-low interrupt enables
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ie_n_q <= tkca_pkg::IE_N_RST;
    end else if (wr_ok && wr_hit(acc, PWRITE, PADDR, tkca_pkg::A_STAT)) begin
      ie_n_q <= PWDATA[tkca_pkg::S_IE +: 3];
    end
  end

  // Open-drain interrupt, low pulls the pin
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !(|(flag_q & ~ie_n_q));
    end
  end
  assign IRQ_OEN = irq_n_q;

  // Expiration latch, cleared only by reset
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      expired_q <= 1'b0;
    end else if (|(alarm_ev & ctrl_q[2:0])) begin
      expired_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  // Oscillator pulses seen since the last tick, kept apart from the divider
  logic [7:0] osc_seen_q;
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      osc_seen_q <= 8'h00;
    end else if (tick) begin
      osc_seen_q <= 8'h00;
    end else if (osc_pulse) begin
      osc_seen_q <= osc_seen_q + 8'h01;
    end
  end

  sequence s_snap_req;
    rd_ok && wr_hit(acc, PWRITE, PADDR, tkca_pkg::A_SNAP);
  endsequence
  sequence s_rtc_quiet;
    !(acc && PWRITE);
  endsequence

  chk_osc_off_hold: assert property (!ctrl_q[tkca_pkg::C_OSC] ##0 s_rtc_quiet |=> $stable(rtc_q))
    else $error("rtc moved with oscillator off");
  chk_tick_divide: assert property (tick |-> osc_pulse && osc_seen_q == 8'h7F)
    else $error("tick not on divide by 128");
  chk_rtc_step: assert property (tick ##0 s_rtc_quiet |=> rtc_q == $past(rtc_q) + 40'h00_0000_0001)
    else $error("rtc did not step on tick");
  chk_manual_halt: assert property (!ctrl_q[tkca_pkg::C_MODE] && ctrl_q[tkca_pkg::C_STOP] ##0 s_rtc_quiet
    |=> $stable(itm_q))
    else $error("timer ran while stopped");
  chk_auto_gate: assert property (ctrl_q[tkca_pkg::C_MODE] && !qif.auto_gate ##0 s_rtc_quiet
    |=> $stable(itm_q))
    else $error("timer ran with gate closed");
  chk_cycle_step: assert property (qif.cycle_step ##0 s_rtc_quiet |=> cyc_q == $past(cyc_q) + 32'h0000_0001)
    else $error("cycle counter missed a step");
  chk_alarm_flag: assert property (alarm_ev[0] |=> flag_q[0] ##1 (flag_q[0] || $past(acc)))
    else $error("alarm flag not set");
  chk_irq_drive: assert property ((|(flag_q & ~ie_n_q)) |=> !IRQ_OEN)
    else $error("interrupt not driven");
  chk_snap_copy: assert property (s_snap_req |=> rtc_h_q == $past(rtc_q) && cyc_h_q == $past(cyc_q))
    else $error("snapshot not taken");
  chk_expire_set: assert property ((|(alarm_ev & ctrl_q[2:0])) |=> expired_q [*2])
    else $error("expiration not latched");
endmodule

//--- verilog/tkca_pkg.sv
package tkca_pkg;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_RTC_LO = 8'h08;
  localparam logic [7:0] A_RTC_HI = 8'h0C;
  localparam logic [7:0] A_ITM_LO = 8'h10;
  localparam logic [7:0] A_ITM_HI = 8'h14;
  localparam logic [7:0] A_CYC = 8'h18;
  localparam logic [7:0] A_RAL_LO = 8'h1C;
  localparam logic [7:0] A_RAL_HI = 8'h20;
  localparam logic [7:0] A_IAL_LO = 8'h24;
  localparam logic [7:0] A_IAL_HI = 8'h28;
  localparam logic [7:0] A_CAL = 8'h2C;
  localparam logic [7:0] A_SNAP = 8'h30;
  localparam logic [7:0] A_EXP = 8'h34;
  // Control bits; counter index k matches its write protect bit k
  localparam int C_WPR = 0;
  localparam int C_WPI = 1;
  localparam int C_WPC = 2;
  localparam int C_RO = 3;
  localparam int C_OSC = 4;
  localparam int C_MODE = 5;
  localparam int C_STOP = 6;
  localparam int C_EDGE_DELAY_SELECT = 7;
  // Status layout: flags low, active-low enables above
  localparam int S_IE = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] IE_N_RST = 3'h7;
  // Time base
  localparam logic [23:0] CLK_HZ = 24'h98_9680;
  localparam logic [23:0] OSC_HZ = 24'h00_8000;
  localparam int US_PER_S = 32'h000F_4240;
  localparam int DLY_LONG_US = 32'h0001_E078;
  localparam int DLY_SHORT_US = 32'h0000_0DAC;
  localparam logic [20:0] LONG_CYC = 21'(DLY_LONG_US * (int'(CLK_HZ) / US_PER_S));
  localparam logic [20:0] SHORT_CYC = 21'(DLY_SHORT_US * (int'(CLK_HZ) / US_PER_S));
  // I/O line qualifier states
  typedef enum logic [3:0] {
    QS_LOW = 4'h1,
    QS_HIGH_PEND = 4'h2,
    QS_HIGH = 4'h4,
    QS_LOW_PEND = 4'h8
  } tkca_qstate_t;
endpackage

//--- verilog/tkca_qual.sv
`timescale 1ns/1ns
module tkca_qual #(
  parameter logic [20:0] LONG_CYC = tkca_pkg::LONG_CYC,
  parameter logic [20:0] SHORT_CYC = tkca_pkg::SHORT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  tkca_qual_if.filt q
);
  tkca_pkg::tkca_qstate_t st_q;
  logic [20:0] cnt_q;
  logic [20:0] lim;
  logic done;
  logic gate_q;
  logic step_q;

  // Hold time picked by delay select; counts only with the oscillator running
  assign lim = q.edge_delay_select ? LONG_CYC : SHORT_CYC;
  assign done = (cnt_q >= lim);
  assign q.auto_gate = gate_q;
  assign q.cycle_step = step_q;

  ////////////////////////////////////////////////////////////////////////
  // Level tracking state machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= tkca_pkg::QS_LOW;
      cnt_q <= 21'h00_0000;
    end else if (q.run_en) begin
      case (st_q)
        tkca_pkg::QS_LOW: begin
          if (q.io_level) begin
            st_q <= tkca_pkg::QS_HIGH_PEND;
            cnt_q <= 21'h00_0000;
          end
        end
        tkca_pkg::QS_HIGH_PEND: begin
          if (!q.io_level) begin
            st_q <= gate_q ? tkca_pkg::QS_LOW_PEND : tkca_pkg::QS_LOW;
            cnt_q <= 21'h00_0000;
          end else if (done) begin
            st_q <= tkca_pkg::QS_HIGH;
          end else begin
            cnt_q <= cnt_q + 21'h00_0001;
          end
        end
        tkca_pkg::QS_HIGH: begin
          if (!q.io_level) begin
            st_q <= tkca_pkg::QS_LOW_PEND;
            cnt_q <= 21'h00_0000;
          end
        end
        tkca_pkg::QS_LOW_PEND: begin
          if (q.io_level) begin
            st_q <= tkca_pkg::QS_HIGH_PEND;
            cnt_q <= 21'h00_0000;
          end else if (done) begin
            st_q <= tkca_pkg::QS_LOW;
          end else begin
            cnt_q <= cnt_q + 21'h00_0001;
          end
        end
        default: begin
          st_q <= tkca_pkg::QS_LOW;
        end
      endcase
    end
  end

  // Auto mode gate: opens after a qualified high, closes after a qualified low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
    end else if (q.run_en && st_q == tkca_pkg::QS_HIGH_PEND && q.io_level && done) begin
      gate_q <= 1'b1;
    end else if (q.run_en && st_q == tkca_pkg::QS_LOW_PEND && !q.io_level && done) begin
      gate_q <= 1'b0;
    end
  end

  // One pulse per falling edge that ends a qualified high time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_q <= 1'b0;
    end else begin
      step_q <= q.run_en && st_q == tkca_pkg::QS_HIGH && !q.io_level;
    end
  end
endmodule

//--- verilog/tkca_qual_if.sv
`timescale 1ns/1ns
interface tkca_qual_if;
  logic io_level;
  logic edge_delay_select;
  logic run_en;
  logic auto_gate;
  logic cycle_step;
  modport core (output io_level, output edge_delay_select, output run_en, input auto_gate, input cycle_step);
  modport filt (input io_level, input edge_delay_select, input run_en, output auto_gate, output cycle_step);
endinterface
